//--- hw/tcs_device.sv
`timescale 1ns/1ps

module tcs_device
    import tcs_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = REFRESH_CYC,
    parameter int unsigned ATTN_PULSE_CYCLES = ATTN_PULSE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic nvm_init_i,
    input wire logic [15:0] sensor_stat_i,
    input wire logic [7:0] slider_pos_i,
    input wire logic [7:0] diag_i,
    input wire logic [6:0] cfg_addr_i,
    output logic [7:0] cfg_data_o,
    output logic low_voltage_sel_o,
    output logic busy_o,
    tcs_link_if.device link
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] shadow [0:CFG_BYTES-1];
    logic [7:0] active [0:CFG_BYTES-1];
    logic [7:0] nvm_a [0:CFG_BYTES-1];
    logic [7:0] nvm_b [0:CFG_BYTES-1];
    logic [1:0] slot_ok;
    logic slot_new;

    tcs_dev_state_t state;
    tcs_dev_state_t next_state;
    logic [6:0] idx;
    logic [7:0] cmd_result;
    logic ack;
    logic [7:0] rdata;
    logic attn_oe_n;
    logic [15:0] prev_stat;
    logic [7:0] prev_slider;
    logic attn_pend;
    logic [15:0] pulse_cnt;
    logic [15:0] gap_cnt;

    // ************************************************************
    // decode
    // ************************************************************
    // the host can pull the device into reset over the link
    wire dev_rst = rst_i | link.dev_rst;
    wire [6:0] a7 = link.addr[6:0];
    wire in_cfg = link.addr <= CFG_LAST_ADDR;
    wire in_cmd = (link.addr >= CMD_FIRST_ADDR) & (link.addr <= CMD_LAST_ADDR);
    // requests wait while boot or save walks the arrays
    wire take = link.req & ~ack & (state == D_IDLE);
    wire cfg_wr = take & link.we & in_cfg;
    wire cmd_wr = take & link.we & in_cmd;
    wire save_go = cmd_wr & (link.addr == CMD_CTRL_ADDR) & (link.wdata == CMD_SAVE);
    wire last_idx = idx == CFG_LAST_ADDR[6:0];
    wire save_end = (state == D_SAVE) & last_idx;
    wire boot_end = (state == D_BOOT) & last_idx;
    wire tgt = ~slot_new;

    wire use_new = slot_ok[slot_new];
    wire use_old = slot_ok[~slot_new];
    wire boot_slot = use_new ? slot_new : ~slot_new;
    wire [7:0] slot_byte = boot_slot ? nvm_b[idx] : nvm_a[idx];
    wire [7:0] boot_byte = (use_new | use_old) ? slot_byte : CFG_FACTORY;

    wire [7:0] st_byte = (link.addr == ST_RESULT_ADDR) ? cmd_result :
                         (link.addr == ST_DIAG_ADDR) ? diag_i :
                         (link.addr == ST_BTN_LO_ADDR) ? sensor_stat_i[7:0] :
                         (link.addr == ST_BTN_HI_ADDR) ? sensor_stat_i[15:8] :
                         (link.addr == ST_SLIDER_ADDR) ? slider_pos_i : 8'h00;
    // reads never depend on the low-voltage bit
    wire [7:0] rd_mux = in_cfg ? shadow[a7] : (in_cmd ? 8'h00 : st_byte);

    wire stat_chg = (sensor_stat_i != prev_stat) | (slider_pos_i != prev_slider);
    wire attn_go = attn_pend & (gap_cnt == 16'h0000) & (state != D_BOOT);

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            D_BOOT: if (boot_end) next_state = D_IDLE;
            D_IDLE: if (save_go) next_state = D_SAVE;
            D_SAVE: if (save_end) next_state = D_IDLE;
            default: next_state = D_BOOT;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (dev_rst) begin
            state <= D_BOOT;
            idx <= 7'h00;
        end else begin
            state <= next_state;
            idx <= (next_state != state || state == D_IDLE) ? 7'h00 : idx + 7'h01;
        end
    end

    assign busy_o = state != D_IDLE;

    // ************************************************************
    // arrays
    // ************************************************************
    // only config-range writes reach the shadow
    always_ff @(posedge ref_clk_i) begin
        if (state == D_BOOT) begin
            shadow[idx] <= boot_byte;
        end else if (cfg_wr) begin
            shadow[a7] <= link.wdata;
        end
    end

    // working copy changes only at boot
    always_ff @(posedge ref_clk_i) begin
        if (state == D_BOOT) begin
            active[idx] <= boot_byte;
        end
    end

    // saves go to the older slot so the newest stays intact
    always_ff @(posedge ref_clk_i) begin
        if (state == D_SAVE && !dev_rst && !tgt) begin
            nvm_a[idx] <= shadow[idx];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (state == D_SAVE && !dev_rst && tgt) begin
            nvm_b[idx] <= shadow[idx];
        end
    end

    // flags survive device reset; a save cut by reset leaves its slot invalid
    always_ff @(posedge ref_clk_i) begin
        if (nvm_init_i) begin
            slot_ok <= 2'b00;
            slot_new <= 1'b0;
        end else if (!dev_rst && save_go) begin
            slot_ok[tgt] <= 1'b0;
        end else if (!dev_rst && save_end) begin
            slot_ok[tgt] <= 1'b1;
            slot_new <= tgt;
        end
    end

    // ************************************************************
    // link answer
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (dev_rst) begin
            ack <= 1'b0;
            rdata <= 8'h00;
        end else begin
            ack <= take;
            if (take) begin
                rdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (dev_rst) begin
            cmd_result <= CMD_RES_OK;
        end else if (save_end) begin
            cmd_result <= CMD_RES_OK;
        end else if (cmd_wr & ~save_go) begin
            cmd_result <= CMD_RES_BAD;
        end
    end

    assign link.ack = ack;
    assign link.rdata = rdata;

    // ************************************************************
    // user side view of applied config
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (dev_rst) begin
            low_voltage_sel_o <= 1'b0;
            cfg_data_o <= 8'h00;
        end else begin
            if (state == D_BOOT && idx == CFG3_IDX) begin
                low_voltage_sel_o <= boot_byte[CFG3_LV_BIT];
            end
            cfg_data_o <= (cfg_addr_i > CFG_LAST_ADDR[6:0]) ? 8'h00 : active[cfg_addr_i];
        end
    end

    // ************************************************************
    // attention line
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (dev_rst) begin
            // start from the live inputs so reset alone raises no attention
            prev_stat <= sensor_stat_i;
            prev_slider <= slider_pos_i;
            attn_pend <= 1'b0;
        end else begin
            prev_stat <= sensor_stat_i;
            prev_slider <= slider_pos_i;
            attn_pend <= stat_chg | (attn_pend & ~attn_go);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (dev_rst) begin
            pulse_cnt <= 16'h0000;
            gap_cnt <= 16'h0000;
            attn_oe_n <= 1'b1;
        end else begin
            if (attn_go) begin
                pulse_cnt <= 16'(ATTN_PULSE_CYCLES);
                gap_cnt <= 16'(REFRESH_CYCLES - 1);
            end else begin
                pulse_cnt <= (pulse_cnt != 16'h0000) ? pulse_cnt - 16'h0001 : pulse_cnt;
                gap_cnt <= (gap_cnt != 16'h0000) ? gap_cnt - 16'h0001 : gap_cnt;
            end
            attn_oe_n <= ~(attn_go | (pulse_cnt > 16'h0001));
        end
    end

    // open-drain: only ever pulls low
    assign link.attn_out = 1'b0;
    assign link.attn_oe_n = attn_oe_n;

endmodule // tcs_device

//--- hw/tcs_host.sv
`timescale 1ns/1ps
module tcs_host
    import tcs_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic usr_valid_i,
    input wire logic usr_we_i,
    input wire logic [7:0] usr_addr_i,
    input wire logic [7:0] usr_wdata_i,
    input wire logic lv_setup_i,
    output logic usr_ready_o,
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic status_valid_o,
    output logic [7:0] status_o,
    output logic lv_done_o,
    tcs_link_if.host link
);

    // ************************************************************
    // state
    // ************************************************************
    tcs_host_state_t state;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic dev_rst;
    logic attn_prev;
    logic attn_pend;

    wire idle = state == H_IDLE;
    wire got = req & link.ack;
    wire attn_fall = attn_prev & ~link.attn_line;
    // attention reads come before anything the user asks
    wire go_attn = idle & attn_pend;
    wire go_lv = idle & ~attn_pend & lv_setup_i;
    wire go_usr = idle & ~attn_pend & ~lv_setup_i & usr_valid_i;
    wire result_ok = link.rdata == CMD_RES_OK;

    assign usr_ready_o = idle & ~attn_pend & ~lv_setup_i;

    // ************************************************************
    // request sequencer
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= H_IDLE;
            req <= 1'b0;
            we <= 1'b0;
            addr <= 8'h00;
            wdata <= 8'h00;
            dev_rst <= 1'b0;
        end else begin
            dev_rst <= 1'b0;
            if (go_attn) begin
                state <= H_ATTN;
                req <= 1'b1;
                we <= 1'b0;
                addr <= ST_BTN_LO_ADDR;
            end else if (go_lv) begin
                state <= H_LVW;
                req <= 1'b1;
                we <= 1'b1;
                addr <= {1'b0, CFG3_IDX};
                wdata <= CFG3_LV_SET;
            end else if (go_usr) begin
                state <= H_USER;
                req <= 1'b1;
                we <= usr_we_i;
                addr <= usr_addr_i;
                wdata <= usr_wdata_i;
            end else if (state == H_LVR) begin
                state <= H_IDLE;
            end else if (got && state == H_LVW) begin
                state <= H_LVS;
                req <= 1'b0;
                we <= 1'b1;
                addr <= CMD_CTRL_ADDR;
                wdata <= CMD_SAVE;
            end else if (got && state == H_LVS) begin
                state <= H_LVP;
                req <= 1'b0;
                we <= 1'b0;
                addr <= ST_RESULT_ADDR;
            end else if (!req && (state == H_LVS || state == H_LVP)) begin
                // one quiet cycle between chained requests
                req <= 1'b1;
            end else if (got && state == H_LVP) begin
                req <= 1'b0;
                state <= result_ok ? H_LVR : H_IDLE;
                dev_rst <= result_ok;
            end else if (got) begin
                req <= 1'b0;
                state <= H_IDLE;
            end
        end
    end

    // ************************************************************
    // answers and attention
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            resp_valid_o <= 1'b0;
            resp_data_o <= 8'h00;
            status_valid_o <= 1'b0;
            status_o <= 8'h00;
            lv_done_o <= 1'b0;
        end else begin
            resp_valid_o <= got & (state == H_USER);
            status_valid_o <= got & (state == H_ATTN);
            lv_done_o <= state == H_LVR;
            if (got && state == H_USER) begin
                resp_data_o <= link.rdata;
            end
            if (got && state == H_ATTN) begin
                status_o <= link.rdata;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            attn_prev <= 1'b1;
            attn_pend <= 1'b0;
        end else begin
            attn_prev <= link.attn_line;
            // a new fall wins over launch
            attn_pend <= attn_fall | (attn_pend & ~go_attn);
        end
    end

    assign link.req = req;
    assign link.we = we;
    assign link.addr = addr;
    assign link.wdata = wdata;
    assign link.dev_rst = dev_rst;

endmodule // tcs_host

//--- pkg/tcs_link_if.sv
`timescale 1ns/1ps
interface tcs_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic attn_out;
    logic attn_oe_n;
    logic dev_rst;
    logic attn_line;

    // open-drain line, pulled up when nobody drives
    assign attn_line = attn_oe_n ? 1'b1 : attn_out;

    modport device(input req, input we, input addr, input wdata, input dev_rst,
                   output ack, output rdata, output attn_out, output attn_oe_n);
    modport host(output req, output we, output addr, output wdata, output dev_rst,
                 input ack, input rdata, input attn_line);
endinterface

//--- pkg/tcs_pkg.sv
package tcs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned CFG_BYTES = 127;
    localparam logic [7:0] CFG_LAST_ADDR = 8'h7E;
    localparam logic [7:0] CMD_FIRST_ADDR = 8'h80;
    localparam logic [7:0] CMD_LAST_ADDR = 8'h87;
    localparam logic [7:0] CMD_CTRL_ADDR = 8'h86;
    localparam logic [7:0] ST_RESULT_ADDR = 8'h88;
    localparam logic [7:0] ST_DIAG_ADDR = 8'h89;
    localparam logic [7:0] ST_BTN_LO_ADDR = 8'h8A;
    localparam logic [7:0] ST_BTN_HI_ADDR = 8'h8B;
    localparam logic [7:0] ST_SLIDER_ADDR = 8'h8C;
    localparam logic [6:0] CFG3_IDX = 7'h4F;
    localparam int unsigned CFG3_LV_BIT = 0;
    localparam logic [7:0] CFG3_LV_SET = 8'h01;
    localparam logic [7:0] CFG_FACTORY = 8'h00;
    localparam logic [7:0] CMD_SAVE = 8'h02;
    localparam logic [7:0] CMD_RES_OK = 8'h00;
    localparam logic [7:0] CMD_RES_BAD = 8'hFD;
    // longest time, rounds down
    localparam int unsigned CMD_LATENCY_LIMIT_NS = 10000;
    localparam int unsigned CMD_LATENCY_CYC = CMD_LATENCY_LIMIT_NS / CLK_PERIOD_NS;
    // least times, round up
    localparam int unsigned REFRESH_INTERVAL_NS = 100000;
    localparam int unsigned REFRESH_CYC = (REFRESH_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ATTN_PULSE_NS = 1000;
    localparam int unsigned ATTN_PULSE_CYC = (ATTN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        D_BOOT = 2'b00,
        D_IDLE = 2'b01,
        D_SAVE = 2'b11
    } tcs_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_USER = 3'b001,
        H_ATTN = 3'b011,
        H_LVW = 3'b010,
        H_LVS = 3'b110,
        H_LVP = 3'b111,
        H_LVR = 3'b101
    } tcs_host_state_t;
endpackage

//--- tb/tcs_link_asserts.sv
`timescale 1ns/1ps
module tcs_link_asserts
    import tcs_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = REFRESH_CYC,
    parameter int unsigned ATTN_PULSE_CYCLES = ATTN_PULSE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic attn_out,
    input wire logic attn_oe_n,
    input wire logic dev_rst,
    input wire logic attn_line
);
    // ****************
    // helper counters
    // ****************
    logic [15:0] low_cnt;
    logic [15:0] gap_cnt;
    logic oe_q;
    wire attn_fall = oe_q && !attn_oe_n;
    wire gap_full = (gap_cnt == 16'hFFFF);

    always_ff @(posedge ref_clk_i) begin
        oe_q <= attn_oe_n;
        low_cnt <= (rst_i || dev_rst || attn_oe_n) ? 16'h0000 : low_cnt + 16'h0001;
    end

    // saturates so a long quiet spell never wraps
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gap_cnt <= 16'hFFFF;
        end else if (attn_fall) begin
            gap_cnt <= 16'h0001;
        end else if (!gap_full) begin
            gap_cnt <= gap_cnt + 16'h0001;
        end
    end

    // ****************
    // link properties
    // ****************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_on_req: assert property (ack |-> req)
        else $error("ack without a pending request");
    a_ack_bound: assert property (req && !ack |-> ##[1:300] ack)
        else $error("request not answered in time");
    a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    a_req_drop: assert property (ack |=> !req)
        else $error("request kept after ack");
    a_rdata_hold: assert property ($changed(rdata) && !$past(dev_rst) |-> ack)
        else $error("read data changed outside ack");
    a_attn_drive_low: assert property (!attn_oe_n |-> !attn_out && !attn_line)
        else $error("attention line not low while driven");
    a_attn_pulse_len: assert property ($rose(attn_oe_n) && !$past(dev_rst) |-> low_cnt == ATTN_PULSE_CYCLES)
        else $error("attention pulse length wrong");
    a_attn_spacing: assert property ($fell(attn_oe_n) |-> gap_cnt >= REFRESH_CYCLES)
        else $error("attention pulses too close");
    a_dev_rst_pulse: assert property (dev_rst |=> !dev_rst)
        else $error("device reset longer than one cycle");

    c_save: cover property (req && we && addr == CMD_CTRL_ADDR && wdata == CMD_SAVE && ack);
    c_attn: cover property ($fell(attn_oe_n));
    c_dev_rst: cover property (dev_rst);
endmodule // tcs_link_asserts

//--- tb/test_touch_ctrl_config_store.sv
`timescale 1ns/1ps
module test_touch_ctrl_config_store
    import tcs_pkg::*;
;
    localparam int unsigned REFRESH_SIM = 20;
    localparam int unsigned PULSE_SIM = 3;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic nvm_init_i = 1'b1;
    logic [15:0] sensor_stat_i = 16'h1234;
    logic [7:0] slider_pos_i = 8'h56;
    logic [7:0] diag_i = 8'h9A;
    logic [6:0] cfg_addr_i = 7'h00;
    logic usr_valid_i = 1'b0;
    logic usr_we_i = 1'b0;
    logic [7:0] usr_addr_i = 8'h00;
    logic [7:0] usr_wdata_i = 8'h00;
    logic lv_setup_i = 1'b0;
    logic [7:0] cfg_data_o, resp_data_o, status_o;
    logic low_voltage_sel_o, busy_o, usr_ready_o, resp_valid_o, status_valid_o, lv_done_o;
    int fail_count = 0;
    int cmp_count = 0;
    int n;

    always #12.5 ref_clk_i = ~ref_clk_i;

    tcs_link_if tcs_link_if_inst();

    tcs_device #(.REFRESH_CYCLES(REFRESH_SIM), .ATTN_PULSE_CYCLES(PULSE_SIM)) tcs_device_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .nvm_init_i(nvm_init_i), .sensor_stat_i(sensor_stat_i),
        .slider_pos_i(slider_pos_i), .diag_i(diag_i), .cfg_addr_i(cfg_addr_i), .cfg_data_o(cfg_data_o),
        .low_voltage_sel_o(low_voltage_sel_o), .busy_o(busy_o), .link(tcs_link_if_inst));

    tcs_host tcs_host_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .usr_valid_i(usr_valid_i), .usr_we_i(usr_we_i),
        .usr_addr_i(usr_addr_i), .usr_wdata_i(usr_wdata_i), .lv_setup_i(lv_setup_i), .usr_ready_o(usr_ready_o),
        .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .status_valid_o(status_valid_o),
        .status_o(status_o), .lv_done_o(lv_done_o), .link(tcs_link_if_inst));

    tcs_link_asserts #(.REFRESH_CYCLES(REFRESH_SIM), .ATTN_PULSE_CYCLES(PULSE_SIM)) tcs_link_asserts_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req(tcs_link_if_inst.req), .we(tcs_link_if_inst.we),
        .addr(tcs_link_if_inst.addr), .wdata(tcs_link_if_inst.wdata), .ack(tcs_link_if_inst.ack),
        .rdata(tcs_link_if_inst.rdata), .attn_out(tcs_link_if_inst.attn_out),
        .attn_oe_n(tcs_link_if_inst.attn_oe_n), .dev_rst(tcs_link_if_inst.dev_rst),
        .attn_line(tcs_link_if_inst.attn_line));

    // ****************
    // access tasks
    // ****************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // writes wait for the link ack, reads for the host response
    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int k;
        k = 0;
        @(negedge ref_clk_i);
        usr_valid_i = 1'b1;
        usr_we_i = we;
        usr_addr_i = a;
        usr_wdata_i = d;
        #1;
        while (usr_ready_o !== 1'b1 && k < 2000) begin
            @(negedge ref_clk_i);
            #1;
            k++;
        end
        @(negedge ref_clk_i);
        usr_valid_i = 1'b0;
        while ((we ? tcs_link_if_inst.ack : resp_valid_o) !== 1'b1 && k < 2000) begin
            @(negedge ref_clk_i);
            k++;
        end
        q = resp_data_o;
        chk((k < 2000) ? 8'h01 : 8'h00, 8'h01);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic cfg_chk(input logic [6:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        cfg_addr_i = a;
        @(negedge ref_clk_i);
        chk(cfg_data_o, exp);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < 1000) begin
            @(negedge ref_clk_i);
            k++;
        end
        chk((k < 1000) ? 8'h01 : 8'h00, 8'h01);
    endtask

    task automatic do_reset();
        @(negedge ref_clk_i);
        rst_i = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        rst_i = 1'b0;
        wait_idle();
    endtask

    task automatic save();
        int k;
        k = 0;
        wr(CMD_CTRL_ADDR, CMD_SAVE);
        while (busy_o === 1'b1 && k < 1000) begin
            @(negedge ref_clk_i);
            k++;
        end
        chk((k <= CMD_LATENCY_CYC) ? 8'h01 : 8'h00, 8'h01);
        rd_chk(ST_RESULT_ADDR, CMD_RES_OK);
    endtask

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************
    // test sequence
    // ****************
    initial begin
        #(60000 * CLK_PERIOD_NS);
        fail_count++;
        summarize();
    end

    initial begin
        repeat (10) @(negedge ref_clk_i);
        rst_i = 1'b0;
        nvm_init_i = 1'b0;
        wait_idle();
        for (int i = 0; i < CFG_BYTES; i++) cfg_chk(i[6:0], CFG_FACTORY);
        chk({7'h00, low_voltage_sel_o}, 8'h00);
        wr(8'h00, 8'h5A);
        wr(CFG_LAST_ADDR, 8'hA5);
        rd_chk(8'h00, 8'h5A);
        rd_chk(CFG_LAST_ADDR, 8'hA5);
        cfg_chk(7'h00, CFG_FACTORY);
        do_reset();
        rd_chk(8'h00, CFG_FACTORY);
        cfg_chk(7'h7E, CFG_FACTORY);
        wr(8'h7F, 8'h11);
        wr(ST_DIAG_ADDR, 8'hFF);
        wr(ST_BTN_LO_ADDR, 8'hFF);
        wr(8'hFB, 8'h11);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h09, CFG_FACTORY);
        rd_chk(8'h0A, CFG_FACTORY);
        rd_chk(8'h7B, CFG_FACTORY);
        rd_chk(ST_DIAG_ADDR, diag_i);
        rd_chk(ST_BTN_LO_ADDR, 8'h34);
        rd_chk(ST_BTN_HI_ADDR, 8'h12);
        rd_chk(ST_SLIDER_ADDR, 8'h56);
        wr(8'h00, 8'h5A);
        wr(CFG_LAST_ADDR, 8'hA5);
        for (int a = int'(CMD_FIRST_ADDR); a <= int'(CMD_LAST_ADDR); a++) begin
            wr(a[7:0], 8'h55);
            rd_chk(ST_RESULT_ADDR, CMD_RES_BAD);
            save();
        end
        wr(ST_RESULT_ADDR, 8'h11);
        rd_chk(ST_RESULT_ADDR, CMD_RES_OK);
        cfg_chk(7'h00, CFG_FACTORY);
        do_reset();
        cfg_chk(7'h00, 8'h5A);
        cfg_chk(7'h7E, 8'hA5);
        // reset lands in the middle of the copy
        wr(8'h00, 8'hC3);
        wr(CMD_CTRL_ADDR, CMD_SAVE);
        repeat (20) @(negedge ref_clk_i);
        do_reset();
        cfg_chk(7'h00, 8'h5A);
        chk({7'h00, low_voltage_sel_o}, 8'h00);
        @(negedge ref_clk_i);
        lv_setup_i = 1'b1;
        n = 0;
        while (lv_done_o !== 1'b1 && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        lv_setup_i = 1'b0;
        chk((n < 3000) ? 8'h01 : 8'h00, 8'h01);
        wait_idle();
        chk({7'h00, low_voltage_sel_o}, 8'h01);
        cfg_chk(CFG3_IDX, CFG3_LV_SET);
        rd_chk(8'h00, 8'h5A);
        wr(8'h01, 8'h66);
        rd_chk(8'h01, 8'h66);
        for (int s = 0; s < 2; s++) begin
            @(negedge ref_clk_i);
            sensor_stat_i = (s == 0) ? 16'hBEEF : 16'hBE00;
            slider_pos_i = 8'h77;
            n = 0;
            while (status_valid_o !== 1'b1 && n < 500) begin
                @(negedge ref_clk_i);
                n++;
            end
            chk(status_o, (s == 0) ? 8'hEF : 8'h00);
        end
        repeat (REFRESH_SIM) @(negedge ref_clk_i);
        summarize();
    end
endmodule // test_touch_ctrl_config_store
